//--- seep_pkg.sv
// Constants, command codes and state types of the serial EEPROM command port.
// Assumes a 20 MHz core clock; all times are converted to cycles of it here.
package seep_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;        // Core clock period
  localparam int NS_PER_MS = 1000000;       // Unit conversion
  localparam int TCSL_NS = 250;             // Least select-low time before status
  localparam int TCSL_CYC = (TCSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up
  localparam int TWC_LV_MS = 6;             // Word cycle, low-voltage variant
  localparam int TWC_HV_MS = 2;             // Word cycle, 5 V only variant
  localparam int ARRAY_ERASE_TIME_MS = 6;   // Whole-array erase
  localparam int ARRAY_WRITE_TIME_MS = 15;  // Whole-array write
  localparam int PROG_CYC_LV = TWC_LV_MS * NS_PER_MS / CLK_PERIOD_NS;   // Rounded down
  localparam int PROG_CYC_HV = TWC_HV_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int ERASE_ALL_CYC = ARRAY_ERASE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WRITE_ALL_CYC = ARRAY_WRITE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;                // Program timer width

  // ****************************************
  // Array and frame layout
  // ****************************************
  localparam int ARR_BYTES = 512;           // 4 Kbit
  localparam int ADR_W = 9;                 // Byte address width
  localparam logic [4:0] HDR_LEN_X16 = 5'h0a;  // Opcode plus 8 address bits
  localparam logic [4:0] HDR_LEN_X8 = 5'h0b;   // Opcode plus 9 address bits
  localparam logic [4:0] FULL_LEN_X16 = 5'h1a; // Header plus 16 data bits
  localparam logic [4:0] FULL_LEN_X8 = 5'h13;  // Header plus 8 data bits
  localparam logic [4:0] WORD_X16 = 5'h10;
  localparam logic [4:0] WORD_X8 = 5'h08;
  localparam logic [7:0] BYTE_ERASED = 8'hff;

  // ****************************************
  // Opcodes and special sub-codes
  // ****************************************
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_ERASE_WHOLE_ARRAY = 2'h2;
  localparam logic [1:0] SUB_DIS = 2'h0;
  localparam logic [1:0] SUB_EN = 2'h3;

  typedef enum logic [2:0] {CMD_READ, CMD_WRITE, CMD_ERASE, CMD_ERASE_WHOLE_ARRAY, CMD_WRITE_WHOLE_ARRAY,
                            CMD_EN, CMD_DIS} seep_cmd_t;
  typedef enum logic [1:0] {LK_HUNT, LK_FRAME, LK_READ, LK_DONE} seep_lk_t;
  typedef enum logic [1:0] {CR_IDLE, CR_ARMED, CR_BUSY} seep_cr_t;

endpackage

//--- seep_port.sv
// Serial EEPROM command port: three-wire serial slave, array and program timer.
// Assumes the serial clock is a free clock port of its own (stops between frames)
// and that the word size select pin is a static strap.
//
// Summary of operation
// - Size pin high gives 16-bit words
// - Serial input sampled on serial clock rise
// - Output floats except read data or status
// - Status low while busy, high when ready
// - Output floats when chip select falls
// - Start is first edge with select and input high
// - Nothing happens before a start
// - Execute only complete frames
// - Leaves standby when select rises
// - Powers up write-disabled, refusing programming
// - Erase sets word ones, variant start point
// - Status shown after select low long enough
// - Start bit then select low clears status
// - Erase-all sets whole array, self-timed
// - Wide frames: 11 or 27 clocks
// - Narrow frames: 12 or 20 clocks
// - Word cycle 6 ms or 2 ms
// - Array erase 6 ms, array write 15 ms
// - Dummy zero right after last address bit
// - Enable persists; reads ignore enable
// - Select held high reads sequentially
// - Select low resets control, not cycle
`timescale 1ns/100ps
`default_nettype none

module seep_port
  import seep_pkg::*;
#(
  parameter bit LOW_VOLT = 1'b1,                 // 1: low-voltage variant
  parameter int PROG_CYC_LV_P = seep_pkg::PROG_CYC_LV,
  parameter int PROG_CYC_HV_P = seep_pkg::PROG_CYC_HV,
  parameter int ERASE_ALL_CYC_P = seep_pkg::ERASE_ALL_CYC,
  parameter int WRITE_ALL_CYC_P = seep_pkg::WRITE_ALL_CYC
) (
  input wire logic core_clk_in,             // Core clock, 20 MHz
  input wire logic rstn_in,                 // Reset, low; synchronous on core side, asynchronous at the link side hand-over
  input wire logic ce_in,                   // Core clock enable
  input wire logic word_size_select_in,     // High: 16-bit words
  input wire logic cs_in,                   // Chip select, high active
  input wire logic sclk_in,                 // Serial clock (link domain)
  input wire logic serial_in,               // Serial data in
  output logic serial_out,                  // Serial data out level
  output logic serial_oe_out,               // Serial data out enable
  output logic ready_busy_flag_out,         // High when no cycle runs
  output logic prog_enable_out              // Programming enabled
);
  import seep_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial begin
    if (PROG_CYC_LV_P < 1 || PROG_CYC_HV_P < 1 || ERASE_ALL_CYC_P < 1 ||
        WRITE_ALL_CYC_P < 1) begin
      $error("program cycle counts must be at least one");
    end
    if (PROG_CYC_LV_P >= 2**TMR_W || PROG_CYC_HV_P >= 2**TMR_W ||
        ERASE_ALL_CYC_P >= 2**TMR_W || WRITE_ALL_CYC_P >= 2**TMR_W) begin
      $error("program cycle count exceeds timer width");
    end
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] mem_r [ARR_BYTES];            // Storage array, core domain writes
  logic x16;                                // Wide organisation in force
  // Link side
  seep_lk_t lk_st_r;                        // Frame state
  logic [4:0] bit_cnt_r;                    // Bits taken after start
  logic [25:0] sh_r;                        // Incoming shift register
  logic [25:0] sh_nxt;
  logic [4:0] nb;                           // Bit count including this edge
  logic [1:0] op_now;
  logic [8:0] adr_now;
  logic [1:0] spc_now;
  seep_cmd_t cmd_now;                       // Decode at header end
  seep_cmd_t hdr_cmd_r;                     // Command awaiting data
  logic [8:0] hdr_adr_r;
  logic start_det, hdr_hit, full_hit, frm_done;
  logic needs_data;
  logic frm_ok_r;                           // Complete frame held for core
  logic start_tgl_r;                        // Flips on every start
  seep_cmd_t hold_cmd_r;                    // Handed to core, stable
  logic [8:0] hold_adr_r;
  logic [15:0] hold_dat_r;
  logic [15:0] rd_sh_r;                     // Read data, MSB out first
  logic [4:0] rd_left_r;                    // Bits left in word
  logic [8:0] rd_adr_r;                     // Word address being read
  logic [8:0] rd_adr_inc;
  logic [8:0] fetch_adr;
  logic [15:0] fetch_word;
  logic [4:0] word_len;
  logic do_r, rd_oe_r;
  // Core side
  logic cs_s1, cs_s2, cs_d;                 // Select synchroniser
  logic org_s1, org_r;                      // Size strap synchroniser
  logic fok_s1, fok_s2, fok_d;              // Frame-ready synchroniser
  logic stg_s1, stg_s2, stg_d;              // Start toggle synchroniser
  logic fok_rise, stg_evt, cs_rise;
  seep_cr_t cr_st_r;
  logic [TMR_W-1:0] tmr_r;
  seep_cmd_t op_r;
  logic [8:0] adr_r;
  logic [15:0] dat_r;
  logic commit;                             // Cycle ends this cycle
  logic go_busy;                            // Cycle starts this cycle
  logic [2:0] csl_cnt_r;                    // Select low time, saturating
  logic prog_en_r, stat_en_r, stat_oe_r, ready_r;

  // ****************************************
  // Helpers
  // ****************************************
  // Decode opcode plus special sub-code
  function automatic seep_cmd_t dec_cmd(input logic [1:0] op, input logic [1:0] spc);
    seep_cmd_t c;
    c = CMD_READ;
    if (op == OP_READ) begin
      c = CMD_READ;
    end else if (op == OP_WRITE) begin
      c = CMD_WRITE;
    end else if (op == OP_ERASE) begin
      c = CMD_ERASE;
    end else if (spc == SUB_ERASE_WHOLE_ARRAY) begin
      c = CMD_ERASE_WHOLE_ARRAY;
    end else if (spc == SUB_DIS) begin
      c = CMD_DIS;
    end else if (spc == SUB_EN) begin
      c = CMD_EN;
    end else begin
      c = CMD_WRITE_WHOLE_ARRAY;
    end
    return c;
  endfunction

  // Cycle length for a programming command
  function automatic logic [TMR_W-1:0] cyc_of(input seep_cmd_t c);
    logic [TMR_W-1:0] n;
    n = LOW_VOLT ? TMR_W'(PROG_CYC_LV_P) : TMR_W'(PROG_CYC_HV_P);
    if (c == CMD_ERASE_WHOLE_ARRAY) begin
      n = TMR_W'(ERASE_ALL_CYC_P);
    end else if (c == CMD_WRITE_WHOLE_ARRAY) begin
      n = TMR_W'(WRITE_ALL_CYC_P);
    end
    return n;
  endfunction

  // ****************************************
  // Link side decode
  // ****************************************
  // Strap is static, so the core-synchronised copy is safe here
  assign x16 = org_r;
  assign word_len = x16 ? WORD_X16 : WORD_X8;
  assign nb = bit_cnt_r + 5'h01;
  assign sh_nxt = {sh_r[24:0], serial_in};
  assign op_now = x16 ? sh_nxt[9:8] : sh_nxt[10:9];
  assign adr_now = x16 ? {1'b0, sh_nxt[7:0]} : sh_nxt[8:0];
  assign spc_now = x16 ? adr_now[7:6] : adr_now[8:7];
  assign cmd_now = dec_cmd(op_now, spc_now);
  assign needs_data = (cmd_now == CMD_WRITE) || (cmd_now == CMD_WRITE_WHOLE_ARRAY);
  assign start_det = (lk_st_r == LK_HUNT) && serial_in;
  // Header ends after 10 or 11 bits, data after 26 or 19
  assign hdr_hit = (lk_st_r == LK_FRAME) &&
                   (nb == (x16 ? HDR_LEN_X16 : HDR_LEN_X8));
  assign full_hit = (lk_st_r == LK_FRAME) && (hdr_cmd_r != CMD_READ) &&
                    (nb == (x16 ? FULL_LEN_X16 : FULL_LEN_X8));
  // Only a frame with every bit taken is executed
  assign frm_done = (hdr_hit && !needs_data && cmd_now != CMD_READ) || full_hit;

  // Next word address, wrapping at the array end
  assign rd_adr_inc = x16 ? {1'b0, rd_adr_r[7:0] + 8'h01} : rd_adr_r + 9'h001;
  assign fetch_adr = (lk_st_r == LK_READ) ? rd_adr_inc : adr_now;
  // Word fetch, left aligned so the MSB is always bit 15
  assign fetch_word = x16 ? {mem_r[{fetch_adr[7:0], 1'b0}], mem_r[{fetch_adr[7:0], 1'b1}]}
                          : {mem_r[fetch_adr], 8'h00};

  // ****************************************
  // Link side frame logic
  // ****************************************
  // Select low holds the control logic in reset
  always_ff @(posedge sclk_in or negedge cs_in) begin
    if (!cs_in) begin
      lk_st_r <= LK_HUNT;
      bit_cnt_r <= 5'h00;
      sh_r <= 26'h0000000;
      hdr_cmd_r <= CMD_READ;
      hdr_adr_r <= 9'h000;
    end else begin
      case (lk_st_r)
        // Any activity without a start is ignored
        LK_HUNT: begin
          if (start_det) begin
            lk_st_r <= LK_FRAME;
            bit_cnt_r <= 5'h00;
          end
        end
        LK_FRAME: begin
          sh_r <= sh_nxt;
          bit_cnt_r <= nb;
          if (hdr_hit) begin
            hdr_cmd_r <= cmd_now;
            hdr_adr_r <= adr_now;
            if (cmd_now == CMD_READ) begin
              lk_st_r <= LK_READ;
            end else if (!needs_data) begin
              lk_st_r <= LK_DONE;
            end
          end else if (full_hit) begin
            lk_st_r <= LK_DONE;
          end
        end
        // Read streams until select falls
        LK_READ: begin
          lk_st_r <= LK_READ;
        end
        // Further clocks and data are don't care
        default: begin
          lk_st_r <= LK_DONE;
        end
      endcase
    end
  end

  // Read shifter: dummy zero, then data words back to back
  always_ff @(posedge sclk_in or negedge cs_in) begin
    if (!cs_in) begin
      rd_sh_r <= 16'h0000;
      rd_left_r <= 5'h00;
      rd_adr_r <= 9'h000;
      do_r <= 1'b0;
      rd_oe_r <= 1'b0;
    end else if (hdr_hit && cmd_now == CMD_READ) begin
      rd_sh_r <= fetch_word;
      rd_left_r <= word_len;
      rd_adr_r <= adr_now;
      do_r <= 1'b0;
      rd_oe_r <= 1'b1;
    end else if (lk_st_r == LK_READ) begin
      if (rd_left_r == 5'h00) begin
        // Word done: move on while select stays high
        rd_adr_r <= fetch_adr;
        do_r <= fetch_word[15];
        rd_sh_r <= {fetch_word[14:0], 1'b0};
        rd_left_r <= word_len - 5'h01;
      end else begin
        do_r <= rd_sh_r[15];
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        rd_left_r <= rd_left_r - 5'h01;
      end
    end
  end

  // Hand-over to core; not cleared by select so a late look still sees it
  always_ff @(posedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frm_ok_r <= 1'b0;
      start_tgl_r <= 1'b0;
    end else begin
      if (start_det) begin
        start_tgl_r <= !start_tgl_r;
        frm_ok_r <= 1'b0;
      end else if (frm_done) begin
        frm_ok_r <= 1'b1;
      end
    end
  end

  // Command words, written once per frame, read while frame-ready stands
  always_ff @(posedge sclk_in) begin
    if (frm_done) begin
      hold_cmd_r <= full_hit ? hdr_cmd_r : cmd_now;
      hold_adr_r <= full_hit ? hdr_adr_r : adr_now;
      hold_dat_r <= x16 ? sh_nxt[15:0] : {sh_nxt[7:0], 8'h00};
    end
  end

  // ****************************************
  // Core side synchronisers
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      {cs_s1, cs_s2, cs_d} <= 3'h0;
      {org_s1, org_r} <= 2'h0;
      {fok_s1, fok_s2, fok_d} <= 3'h0;
      {stg_s1, stg_s2, stg_d} <= 3'h0;
    end else if (ce_in) begin
      cs_s1 <= cs_in;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      org_s1 <= word_size_select_in;
      org_r <= org_s1;
      fok_s1 <= frm_ok_r;
      fok_s2 <= fok_s1;
      fok_d <= fok_s2;
      stg_s1 <= start_tgl_r;
      stg_s2 <= stg_s1;
      stg_d <= stg_s2;
    end
  end

  assign fok_rise = fok_s2 && !fok_d;
  assign stg_evt = stg_s2 ^ stg_d;
  assign cs_rise = cs_s2 && !cs_d;
  assign commit = (cr_st_r == CR_BUSY) && (tmr_r == TMR_W'(1));
  // Low-voltage starts at select fall, 5 V only at the last clock edge
  assign go_busy = ((cr_st_r == CR_ARMED) && !cs_s2) ||
                   ((cr_st_r == CR_IDLE) && fok_rise && prog_en_r && !LOW_VOLT &&
                    hold_cmd_r != CMD_EN && hold_cmd_r != CMD_DIS &&
                    hold_cmd_r != CMD_READ);

  // ****************************************
  // Core command sequencer and program timer
  // ****************************************
  // A running cycle finishes whatever select does
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cr_st_r <= CR_IDLE;
      tmr_r <= '0;
      op_r <= CMD_READ;
      adr_r <= 9'h000;
      dat_r <= 16'h0000;
    end else if (ce_in) begin
      case (cr_st_r)
        CR_IDLE: begin
          if (fok_rise) begin
            op_r <= hold_cmd_r;
            adr_r <= hold_adr_r;
            dat_r <= hold_dat_r;
            tmr_r <= cyc_of(hold_cmd_r);
            if (go_busy) begin
              cr_st_r <= CR_BUSY;
            end else if (prog_en_r && hold_cmd_r != CMD_EN &&
                         hold_cmd_r != CMD_DIS && hold_cmd_r != CMD_READ) begin
              cr_st_r <= CR_ARMED;
            end
          end
        end
        CR_ARMED: begin
          if (go_busy) begin
            cr_st_r <= CR_BUSY;
          end else if (stg_evt) begin
            cr_st_r <= CR_IDLE;             // New frame cancels
          end
        end
        CR_BUSY: begin
          tmr_r <= tmr_r - TMR_W'(1);
          if (commit) begin
            cr_st_r <= CR_IDLE;
          end
        end
        default: begin
          cr_st_r <= CR_IDLE;
        end
      endcase
    end
  end

  // Array update at cycle end; reset leaves it erased
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < ARR_BYTES; i++) begin
        mem_r[i] <= BYTE_ERASED;
      end
    end else if (ce_in && commit) begin
      case (op_r)
        CMD_ERASE: begin
          if (x16) begin
            mem_r[{adr_r[7:0], 1'b0}] <= BYTE_ERASED;
            mem_r[{adr_r[7:0], 1'b1}] <= BYTE_ERASED;
          end else begin
            mem_r[adr_r] <= BYTE_ERASED;
          end
        end
        CMD_WRITE: begin
          if (x16) begin
            mem_r[{adr_r[7:0], 1'b0}] <= dat_r[15:8];
            mem_r[{adr_r[7:0], 1'b1}] <= dat_r[7:0];
          end else begin
            mem_r[adr_r] <= dat_r[15:8];
          end
        end
        // Whole array: erase, or write with built-in erase
        default: begin
          for (int i = 0; i < ARR_BYTES; i++) begin
            if (op_r == CMD_ERASE_WHOLE_ARRAY) begin
              mem_r[i] <= BYTE_ERASED;
            end else if (x16) begin
              mem_r[i] <= i[0] ? dat_r[7:0] : dat_r[15:8];
            end else begin
              mem_r[i] <= dat_r[15:8];
            end
          end
        end
      endcase
    end
  end

  // Programming enable; reads never look at it
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      prog_en_r <= 1'b0;
    end else if (ce_in && fok_rise && cr_st_r == CR_IDLE) begin
      if (hold_cmd_r == CMD_EN) begin
        prog_en_r <= 1'b1;
      end else if (hold_cmd_r == CMD_DIS) begin
        prog_en_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Ready/busy status
  // ****************************************
  // Select low time, saturating at the least low time
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      csl_cnt_r <= 3'h0;
    end else if (ce_in) begin
      if (cs_s2) begin
        csl_cnt_r <= 3'h0;
      end else if (csl_cnt_r < 3'(TCSL_CYC)) begin
        csl_cnt_r <= csl_cnt_r + 3'h1;
      end
    end
  end

  // Status armed by a cycle start; a start bit disarms it, the set wins
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      stat_en_r <= 1'b0;
      stat_oe_r <= 1'b0;
      ready_r <= 1'b1;
    end else if (ce_in) begin
      ready_r <= !(go_busy || (cr_st_r == CR_BUSY && !commit));
      if (go_busy) begin
        stat_en_r <= 1'b1;
      end else if (stg_evt) begin
        stat_en_r <= 1'b0;
      end
      if (!cs_s2 || stg_evt) begin
        stat_oe_r <= 1'b0;
      end else if (cs_rise && (stat_en_r || go_busy) &&
                   csl_cnt_r >= 3'(TCSL_CYC)) begin
        stat_oe_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Enable gated by the pin so the output floats at the select fall itself
  assign serial_oe_out = cs_in && (rd_oe_r || stat_oe_r);
  assign serial_out = rd_oe_r ? do_r : ready_r;
  assign ready_busy_flag_out = ready_r;
  assign prog_enable_out = prog_en_r;

endmodule // seep_port

`default_nettype wire

//--- seep_port_checker.sv
// Pin checks for the command port, core clock side.
// Assumes a bind onto each port instance; link side left to the bench.
`timescale 1ns/100ps
`default_nettype none
module seep_port_checker #(
  parameter int WRITE_ALL_CYC_P = 40 // Longest self-timed cycle
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rstn_in, // Reset, low
  input wire logic ce_in, // Clock enable
  input wire logic cs_in, // Chip select
  input wire logic serial_out, // Data out level
  input wire logic serial_oe_out, // Data out enable
  input wire logic ready_busy_flag_out, // Ready flag
  input wire logic prog_enable_out // Program enable
);
  // ****************************************
  // Busy length and pin relations
  // ****************************************
  int busy_cnt_r; // Busy cycles so far
  // Timer freezes with ce, as the cycle timer does
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || ready_busy_flag_out) busy_cnt_r <= 0;
    else if (ce_in) busy_cnt_r <= busy_cnt_r + 1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_oe_needs_cs: assert property (
    serial_oe_out |-> cs_in) else $error("oe without cs");
  a_reset_disables: assert property (
    $rose(rstn_in) |-> !prog_enable_out && ready_busy_flag_out) else $error("reset state");
  a_reset_quiet: assert property (
    $rose(rstn_in) |-> !serial_oe_out) else $error("oe after reset");
  a_busy_needs_en: assert property (
    $fell(ready_busy_flag_out) |-> prog_enable_out) else $error("cycle while disabled");
  a_busy_bounded: assert property (
    busy_cnt_r <= WRITE_ALL_CYC_P + 8) else $error("cycle too long");
  a_enable_holds: assert property (
    !ready_busy_flag_out |=> $stable(prog_enable_out)) else $error("enable moved");
  a_idle_no_change: assert property (
    !cs_in [*8] |=> $stable(prog_enable_out)) else $error("change while idle");
  a_status_low_busy: assert property (
    (serial_oe_out && !ready_busy_flag_out) [*3] |-> !serial_out) else $error("status high");
  cover property ($fell(ready_busy_flag_out));
  cover property (serial_oe_out && !ready_busy_flag_out);
  cover property ($rose(prog_enable_out));
endmodule // seep_port_checker
bind seep_port seep_port_checker #(.WRITE_ALL_CYC_P(WRITE_ALL_CYC_P)) u_seep_port_checker (
  .core_clk_in, .rstn_in, .ce_in, .cs_in, .serial_out, .serial_oe_out,
  .ready_busy_flag_out, .prog_enable_out);
`default_nettype wire

//--- seep_master.sv
// Host model: select, serial clock and data in; samples data out.
// Assumes it faces the port's pins; its clock runs only inside frames.
`timescale 1ns/100ps
`default_nettype none
module seep_master (
  input wire logic so_in, // Data out level
  input wire logic oe_in, // Data out enable
  output logic cs_out, // Chip select
  output logic sclk_out, // Serial clock
  output logic din_out // Serial data in
);
  logic ph = 1'b0; // Free 125 ns phase
  logic lvl = 1'b0; // Line as seen
  logic [31:0] q = 32'h0; // Line samples, newest low
  initial {cs_out, sclk_out, din_out} = 3'h0;
  // Phase unrelated to the core clock
  initial begin
    #7;
    forever #62.5 ph = ~ph;
  end
  // Released line flips, so stale data never passes
  always @(so_in, oe_in) lvl = oe_in ? so_in : ~lvl;
  task automatic sel(input logic b);
    @(negedge ph);
    cs_out <= b;
  endtask
  // Bits go out MSB first; select drops after the last
  task automatic frame(input int n, input logic [31:0] v);
    @(negedge ph);
    cs_out <= 1'b1; // Clock and data low here
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge ph);
      q <= {q[30:0], lvl};
      sclk_out <= 1'b0;
      din_out <= v[i];
      @(posedge ph);
      sclk_out <= 1'b1;
    end
    @(negedge ph);
    q <= {q[30:0], lvl};
    sclk_out <= 1'b0;
    din_out <= 1'b0;
    cs_out <= 1'b0;
  endtask
endmodule // seep_master
`default_nettype wire

//--- serial_eeprom_command_port_tb.sv
// Bench: byte model of the array against the port, table of commands.
// Assumes the host model drives the pins; the strap moves only in reset.
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_command_port_tb;
  logic core_clk_in = 1'b0; // Core clock
  logic rstn_in = 1'b0; // Reset, low
  logic ce_in = 1'b1; // Clock enable, dropped during the freeze check
  logic word_size_select_in = 1'b0; // Word size strap
  logic cs, sclk, din, so, oe, rdy, pen; // Pins and flags
  logic [7:0] mem [512]; // Byte model
  logic en = 1'b0; // Model enable
  logic [31:0] rs = 32'h18; // Random state
  logic [8:0] ra; // Address of a pass
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  // Ends disabled
  logic [3:0] tbl [14] = '{4'h4, 4'h3, 4'h5, 4'h8, 4'h4, 4'h8, 4'hc, 4'h8, 4'h2, 4'h1, 4'h8,
                          4'h0, 4'h4, 4'h8};
  seep_port #(.PROG_CYC_LV_P(200), .PROG_CYC_HV_P(100), .ERASE_ALL_CYC_P(300),
    .WRITE_ALL_CYC_P(400)) u_seep_port (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .ce_in(ce_in), .word_size_select_in(word_size_select_in), .cs_in(cs), .sclk_in(sclk),
    .serial_in(din), .serial_out(so), .serial_oe_out(oe), .ready_busy_flag_out(rdy),
    .prog_enable_out(pen));
  seep_master u_seep_master (.so_in(so), .oe_in(oe), .cs_out(cs), .sclk_out(sclk),
    .din_out(din));
  initial forever #25 core_clk_in = ~core_clk_in;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One command with two idle clocks ahead of the start; model follows
  task automatic cmd(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                     input logic cut);
    logic w;
    logic [1:0] sub;
    logic lng;
    logic prog;
    logic [31:0] v;
    int n;
    int k;
    w = word_size_select_in;
    sub = w ? a[7:6] : a[8:7];
    lng = (op == 2'h0) ? (sub == 2'h1) : (op != 2'h3);
    prog = en && !cut && op != 2'h2 && !(op == 2'h0 && sub[1] == sub[0]);
    v = w ? {5'h1, op, a[7:0], d} : {11'h1, op, a, d[7:0]};
    n = w ? (lng ? 29 : 13) : (lng ? 22 : 14);
    if (!lng) v = v >> (w ? 16 : 8);
    if (op == 2'h2 && !w) begin
      v = v << 8;
      n = n + 8;
    end
    if (cut) begin
      v = v >> 9;
      n = n - 9;
    end
    repeat (6) @(posedge core_clk_in);
    u_seep_master.frame(n, v);
    if (op == 2'h0 && sub == 2'h3) en = 1'b1;
    if (op == 2'h0 && sub == 2'h0) en = 1'b0;
    for (int i = 0; i < 512; i++)
      if (prog && (op == 2'h0 || (w ? i[8:1] == a[7:0] : i[8:0] == a)))
        mem[i] = (op == 2'h3 || op == 2'h0 && sub == 2'h2) ? 8'hff : w && !i[0] ? d[15:8] : d[7:0];
    repeat (8) @(posedge core_clk_in);
    if (op == 2'h2)
      chk("read", u_seep_master.q[16:0], w ? {1'b0, mem[{a[7:0], 1'b0}],
          mem[{a[7:0], 1'b1}]} : {1'b0, mem[a], mem[a + 9'h1]});
    chk("enable", pen, en);
    if (prog) begin
      u_seep_master.sel(1'b1);
      repeat (6) @(posedge core_clk_in);
      chk("busy", {oe, u_seep_master.lvl, rdy}, 3'h4);
      // Enable low freezes the cycle timer, so busy must persist
      ce_in <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      chk("freeze", {rdy, pen}, {1'b0, en});
      ce_in <= 1'b1;
      for (k = 0; k < 2000 && rdy !== 1'b1; k++) @(posedge core_clk_in);
      chk("cycle", k < 401, 1'b1);
      repeat (4) @(posedge core_clk_in);
      chk("ready", {oe, u_seep_master.lvl}, 2'h3);
      u_seep_master.frame(1, 32'h1);
      @(posedge core_clk_in);
      chk("release", oe, 1'b0);
    end else
      chk("idle", rdy, 1'b1);
  endtask
  initial begin
    for (int p = 0; p < 2; p++) begin
      rstn_in <= 1'b0;
      word_size_select_in <= p[0];
      repeat (10) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      en = 1'b0;
      foreach (mem[i]) mem[i] = 8'hff;
      chk("reset", {pen, rdy, oe}, 3'h2);
      rs = xs(rs);
      ra = rs[8:0];
      foreach (tbl[i]) begin
        rs = xs(rs);
        cmd(tbl[i][3:2], tbl[i][3:2] != 2'h0 ? ra : p[0] ? {1'b0, tbl[i][1:0], 6'h0}
            : {tbl[i][1:0], 7'h0}, rs[15:0], tbl[i] == 4'h5);
      end
    end
    stop_test();
  end
  // Hang limit
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end
endmodule // serial_eeprom_command_port_tb
`default_nettype wire
